// [logic/fgt_pkg.sv]
// Constants and types shared by the fine gain trim register bank
// Summary of operation
// RULE1: Core 0 trim in bits 4:0, index 0x360
// RULE2: Core 1 trim in bits 4:0, index 0x361
// RULE3: Core 2 uses index 0x362 on pair A
// RULE4: Core 2 uses index 0x363 on pair B
// RULE5: Core 3 uses index 0x364 on pair C
// RULE6: Core 3 uses index 0x365 on pair D
// RULE7: Core 4 trim in bits 4:0, index 0x366
// RULE8: Core 5 trim in bits 4:0, index 0x367
// RULE9: Software keeps reserved bits 7:5 at zero
// RULE10: Trim defaults are loaded from fuse ROM
// RULE11: Registers read back last written or loaded value
package fgt_pkg;

  // Bank geometry
  localparam int NUM_REGS   = 8;
  localparam int REG_W      = 8;
  localparam int TRIM_W     = 5;
  localparam int TRIM_LSB   = 0;
  localparam int TRIM_MSB   = 4;
  localparam int RSVD_LSB   = 5;
  localparam int RSVD_MSB   = 7;

  // Bus geometry; byte address is four times the register index
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  localparam int IDX_W      = 10;
  localparam int IDX_LSB    = 2;

  // Register indices
  localparam logic [IDX_W-1:0] IDX_CORE0  = 10'h360;
  localparam logic [IDX_W-1:0] IDX_CORE1  = 10'h361;
  localparam logic [IDX_W-1:0] IDX_CORE2A = 10'h362;
  localparam logic [IDX_W-1:0] IDX_CORE2B = 10'h363;
  localparam logic [IDX_W-1:0] IDX_CORE3C = 10'h364;
  localparam logic [IDX_W-1:0] IDX_CORE3D = 10'h365;
  localparam logic [IDX_W-1:0] IDX_CORE4  = 10'h366;
  localparam logic [IDX_W-1:0] IDX_CORE5  = 10'h367;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h368;

  // Bank slots
  localparam int SLOT_CORE0  = 0;
  localparam int SLOT_CORE1  = 1;
  localparam int SLOT_CORE2A = 2;
  localparam int SLOT_CORE2B = 3;
  localparam int SLOT_CORE3C = 4;
  localparam int SLOT_CORE3D = 5;
  localparam int SLOT_CORE4  = 6;
  localparam int SLOT_CORE5  = 7;

  // Reset values and status fields
  localparam logic [REG_W-1:0]      TRIM_RST      = 8'h00;
  localparam logic [AXI_DATA_W-1:0] RDATA_RST     = 32'h0000_0000;
  localparam int                    STAT_FUSE_BIT = 0;
  localparam int                    STAT_SELB_BIT = 1;
  localparam int                    STAT_SELD_BIT = 2;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Carriers
  typedef logic [REG_W-1:0] fgt_byte_t;
  typedef fgt_byte_t [NUM_REGS-1:0] fgt_bank_t;

  typedef struct packed {
    logic [TRIM_W-1:0] c5;
    logic [TRIM_W-1:0] c4;
    logic [TRIM_W-1:0] c3;
    logic [TRIM_W-1:0] c2;
    logic [TRIM_W-1:0] c1;
    logic [TRIM_W-1:0] c0;
  } fgt_core_trims_t;

  typedef struct packed {
    logic sel_d;
    logic sel_b;
  } fgt_input_sel_t;

  // Bus channel states
  typedef enum logic [2:0] {
    WR_COLLECT = 3'b001,
    WR_APPLY   = 3'b010,
    WR_RESP    = 3'b100
  } fgt_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } fgt_rd_state_t;

endpackage

// [logic/fgt_trim_reg.sv]
// One trim register loaded by software or by fuse ROM
`timescale 1ns/1ns
module fgt_trim_reg #(
  parameter logic [7:0] RST_VAL = fgt_pkg::TRIM_RST
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             sw_we,
  input  wire fgt_pkg::fgt_byte_t sw_data,
  input  wire logic             fuse_we,
  input  wire fgt_pkg::fgt_byte_t fuse_data,
  output fgt_pkg::fgt_byte_t    trim_q
);

  fgt_pkg::fgt_byte_t trim_d;

  // Software write beats a fuse load in the same cycle
  assign trim_d = sw_we ? sw_data : (fuse_we ? fuse_data : trim_q);

  // Storage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trim_q <= RST_VAL;
    else
      trim_q <= trim_d;
  end

endmodule // fgt_trim_reg

// [logic/fgt_trim_select.sv]
// Picks the trim for a core that alternates between two input pairs
`timescale 1ns/1ns
module fgt_trim_select (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        sel_second,
  input  wire logic [4:0]  trim_first,
  input  wire logic [4:0]  trim_second,
  output logic [4:0]       applied_q
);

  logic [4:0] applied_d;

  // Second pair trim replaces the first while it is selected
  assign applied_d = sel_second ? trim_second : trim_first;

  // Registered trim toward the core
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      applied_q <= 5'h00;
    else
      applied_q <= applied_d;
  end

endmodule // fgt_trim_select

// [logic/fgt_regs.sv]
// AXI4-Lite fine gain trim register bank for six converter cores
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
module fgt_regs (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [11:0]              s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [11:0]              s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     fuse_load_valid,
  input  wire fgt_pkg::fgt_bank_t       fuse_trim_bank,
  input  wire fgt_pkg::fgt_input_sel_t  core_input_sel,
  output fgt_pkg::fgt_core_trims_t      core_trims,
  output logic                          fuse_loaded
);

  // Write channel state
  fgt_pkg::fgt_wr_state_t  wr_state_q;
  logic                    awready_q;
  logic                    wready_q;
  logic                    aw_held_q;
  logic                    w_held_q;
  logic [11:0]             awaddr_q;
  logic [31:0]             wdata_q;
  logic [3:0]              wstrb_q;
  logic                    bvalid_q;
  logic [1:0]              bresp_q;

  // Read channel state
  fgt_pkg::fgt_rd_state_t  rd_state_q;
  logic                    arready_q;
  logic                    rvalid_q;
  logic [31:0]             rdata_q;
  logic [1:0]              rresp_q;

  // Block state
  logic                    fuse_loaded_q;
  fgt_pkg::fgt_bank_t      bank_q;
  logic [4:0]              core2_q;
  logic [4:0]              core3_q;

  // Handshake decode
  wire                     aw_fire;
  wire                     w_fire;
  wire                     ar_fire;
  wire                     aw_have;
  wire                     w_have;
  assign aw_fire = s_axi_awvalid && awready_q;
  assign w_fire  = s_axi_wvalid && wready_q;
  assign ar_fire = s_axi_arvalid && arready_q;
  assign aw_have = aw_held_q || aw_fire;
  assign w_have  = w_held_q || w_fire;

  // Write address decode
  wire [9:0]               wr_idx;
  wire [9:0]               wr_off;
  wire                     wr_trim_hit;
  wire                     wr_stat_hit;
  wire                     wr_apply;
  wire                     wr_lane0;
  assign wr_idx      = awaddr_q[11:2];
  assign wr_off      = wr_idx - fgt_pkg::IDX_CORE0;
  assign wr_trim_hit = (wr_idx >= fgt_pkg::IDX_CORE0) && (wr_idx <= fgt_pkg::IDX_CORE5);
  assign wr_stat_hit = (wr_idx == fgt_pkg::IDX_STATUS);
  assign wr_apply    = (wr_state_q == fgt_pkg::WR_APPLY);
  assign wr_lane0    = wstrb_q[0];

  // Read address decode
  wire [9:0]               rd_idx;
  wire [9:0]               rd_off;
  wire                     rd_trim_hit;
  wire                     rd_stat_hit;
  wire [7:0]               rd_byte;
  wire [31:0]              stat_word;
  wire [31:0]              rd_word;
  assign rd_idx      = s_axi_araddr[11:2];
  assign rd_off      = rd_idx - fgt_pkg::IDX_CORE0;
  assign rd_trim_hit = (rd_idx >= fgt_pkg::IDX_CORE0) && (rd_idx <= fgt_pkg::IDX_CORE5);
  assign rd_stat_hit = (rd_idx == fgt_pkg::IDX_STATUS);
  assign rd_byte     = bank_q[rd_off[2:0]];

  // Status word: fuse load seen and current input pair selects
  assign stat_word = {29'h0000_0000, core_input_sel.sel_d, core_input_sel.sel_b, fuse_loaded_q};

  // Read mux, upper bits read as zero
  assign rd_word = rd_trim_hit ? {24'h00_0000, rd_byte} : // RULE11
                   (rd_stat_hit ? stat_word : fgt_pkg::RDATA_RST);

  // Write channel: collect address and data in any order, apply, respond
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_q <= fgt_pkg::WR_COLLECT;
      awready_q  <= 1'b1;
      wready_q   <= 1'b1;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      awaddr_q   <= 12'h000;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= fgt_pkg::RESP_OKAY;
    end
    else
    begin
      case (wr_state_q)
        fgt_pkg::WR_COLLECT:
        begin
          if (aw_fire)
          begin
            awaddr_q  <= s_axi_awaddr;
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
          end
          if (w_fire)
          begin
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
          end
          if (aw_have && w_have)
            wr_state_q <= fgt_pkg::WR_APPLY;
        end
        fgt_pkg::WR_APPLY:
        begin
          bvalid_q   <= 1'b1;
          bresp_q    <= (wr_trim_hit || wr_stat_hit) ? fgt_pkg::RESP_OKAY : fgt_pkg::RESP_SLVERR;
          aw_held_q  <= 1'b0;
          w_held_q   <= 1'b0;
          wr_state_q <= fgt_pkg::WR_RESP;
        end
        fgt_pkg::WR_RESP:
        begin
          if (s_axi_bready)
          begin
            bvalid_q   <= 1'b0;
            awready_q  <= 1'b1;
            wready_q   <= 1'b1;
            wr_state_q <= fgt_pkg::WR_COLLECT;
          end
        end
        default:
        begin
          wr_state_q <= fgt_pkg::WR_COLLECT;
        end
      endcase
    end
  end

  // Read channel: one read under way, data registered at acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_q <= fgt_pkg::RD_IDLE;
      arready_q  <= 1'b1;
      rvalid_q   <= 1'b0;
      rdata_q    <= fgt_pkg::RDATA_RST;
      rresp_q    <= fgt_pkg::RESP_OKAY;
    end
    else
    begin
      case (rd_state_q)
        fgt_pkg::RD_IDLE:
        begin
          if (ar_fire)
          begin
            rdata_q    <= rd_word; // RULE11
            rresp_q    <= (rd_trim_hit || rd_stat_hit) ? fgt_pkg::RESP_OKAY : fgt_pkg::RESP_SLVERR;
            rvalid_q   <= 1'b1;
            arready_q  <= 1'b0;
            rd_state_q <= fgt_pkg::RD_RESP;
          end
        end
        fgt_pkg::RD_RESP:
        begin
          if (s_axi_rready)
          begin
            rvalid_q   <= 1'b0;
            arready_q  <= 1'b1;
            rd_state_q <= fgt_pkg::RD_IDLE;
          end
        end
        default:
        begin
          rd_state_q <= fgt_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Sticky flag: fuse contents have been taken since reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fuse_loaded_q <= 1'b0;
    else if (fuse_load_valid)
      fuse_loaded_q <= 1'b1; // RULE10
  end

  // Eight trim registers, software or fuse loaded, all bits stored
  genvar gi;
  generate
    for (gi = 0; gi < fgt_pkg::NUM_REGS; gi = gi + 1)
    begin : g_trim
      wire sw_we;
      assign sw_we = wr_apply && wr_trim_hit && wr_lane0 && (wr_off[2:0] == 3'(gi)); // RULE11
      fgt_trim_reg #(
        .RST_VAL (fgt_pkg::TRIM_RST)
      ) u_trim (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .sw_we     (sw_we),
        .sw_data   (wdata_q[7:0]),
        .fuse_we   (fuse_load_valid), // RULE10
        .fuse_data (fuse_trim_bank[gi]),
        .trim_q    (bank_q[gi])
      );
    end
  endgenerate

  // Core 2 trim follows its selected input pair
  fgt_trim_select u_core2_sel (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .sel_second  (core_input_sel.sel_b), // RULE3 RULE4
    .trim_first  (bank_q[fgt_pkg::SLOT_CORE2A][4:0]),
    .trim_second (bank_q[fgt_pkg::SLOT_CORE2B][4:0]),
    .applied_q   (core2_q)
  );

  // Core 3 trim follows its selected input pair
  fgt_trim_select u_core3_sel (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .sel_second  (core_input_sel.sel_d), // RULE5 RULE6
    .trim_first  (bank_q[fgt_pkg::SLOT_CORE3C][4:0]),
    .trim_second (bank_q[fgt_pkg::SLOT_CORE3D][4:0]),
    .applied_q   (core3_q)
  );

  // Trim fields toward the cores, reserved bits not used
  assign core_trims.c0 = bank_q[fgt_pkg::SLOT_CORE0][4:0]; // RULE1
  assign core_trims.c1 = bank_q[fgt_pkg::SLOT_CORE1][4:0]; // RULE2
  assign core_trims.c2 = core2_q;
  assign core_trims.c3 = core3_q;
  assign core_trims.c4 = bank_q[fgt_pkg::SLOT_CORE4][4:0]; // RULE7
  assign core_trims.c5 = bank_q[fgt_pkg::SLOT_CORE5][4:0]; // RULE8

  // Bus outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign fuse_loaded   = fuse_loaded_q;

  // Helper views for checks
  wire [4:0] trim2a;
  wire [4:0] trim2b;
  wire [4:0] trim3c;
  wire [4:0] trim3d;
  assign trim2a = bank_q[fgt_pkg::SLOT_CORE2A][4:0];
  assign trim2b = bank_q[fgt_pkg::SLOT_CORE2B][4:0];
  assign trim3c = bank_q[fgt_pkg::SLOT_CORE3C][4:0];
  assign trim3d = bank_q[fgt_pkg::SLOT_CORE3D][4:0];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Software write of one register
  sequence s_sw_write(logic [9:0] idx);
    wr_apply && (wr_idx == idx) && wr_lane0;
  endsequence

  // Write followed by selecting the matching pair
  sequence s_write_then_sel(logic [9:0] idx, logic sel, logic want);
    s_sw_write(idx) ##1 (sel == want);
  endsequence

  property p_core0_write;
    s_sw_write(fgt_pkg::IDX_CORE0) |=> (core_trims.c0 == $past(wdata_q[4:0]));
  endproperty
  a_core0_write: assert property (p_core0_write) else $error("core 0 trim not written"); // RULE1

  property p_core1_write;
    s_sw_write(fgt_pkg::IDX_CORE1) |=> (core_trims.c1 == $past(wdata_q[4:0]));
  endproperty
  a_core1_write: assert property (p_core1_write) else $error("core 1 trim not written"); // RULE2

  property p_core2_a;
    s_write_then_sel(fgt_pkg::IDX_CORE2A, core_input_sel.sel_b, 1'b0) |=> (core_trims.c2 == $past(wdata_q[4:0], 2));
  endproperty
  a_core2_a: assert property (p_core2_a) else $error("core 2 pair A trim not applied"); // RULE3

  property p_core2_b;
    core_input_sel.sel_b |=> (core_trims.c2 == $past(trim2b));
  endproperty
  a_core2_b: assert property (p_core2_b) else $error("core 2 pair B trim not applied"); // RULE4

  property p_core3_c;
    !core_input_sel.sel_d |=> (core_trims.c3 == $past(trim3c));
  endproperty
  a_core3_c: assert property (p_core3_c) else $error("core 3 pair C trim not applied"); // RULE5

  property p_core3_d;
    s_write_then_sel(fgt_pkg::IDX_CORE3D, core_input_sel.sel_d, 1'b1) |=> (core_trims.c3 == $past(wdata_q[4:0], 2));
  endproperty
  a_core3_d: assert property (p_core3_d) else $error("core 3 pair D trim not applied"); // RULE6

  property p_core4_write;
    s_sw_write(fgt_pkg::IDX_CORE4) |=> (core_trims.c4 == $past(wdata_q[4:0]));
  endproperty
  a_core4_write: assert property (p_core4_write) else $error("core 4 trim not written"); // RULE7

  property p_core5_write;
    s_sw_write(fgt_pkg::IDX_CORE5) |=> (core_trims.c5 == $past(wdata_q[4:0]));
  endproperty
  a_core5_write: assert property (p_core5_write) else $error("core 5 trim not written"); // RULE8

  property p_fuse_load;
    (fuse_load_valid && !wr_apply) |=> (bank_q == $past(fuse_trim_bank)) && fuse_loaded;
  endproperty
  a_fuse_load: assert property (p_fuse_load) else $error("fuse contents not loaded"); // RULE10

  property p_read_back;
    (ar_fire && rd_trim_hit) |=> s_axi_rvalid && (s_axi_rdata == {24'h00_0000, $past(rd_byte)});
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data differs from register"); // RULE11

  property p_write_resp;
    (aw_have && w_have && (wr_state_q == fgt_pkg::WR_COLLECT)) |=> wr_apply ##1 s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response late"); // RULE11

  property p_unmapped_write;
    (wr_apply && !wr_trim_hit && !wr_stat_hit) |=> (s_axi_bresp == fgt_pkg::RESP_SLVERR);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write not refused");

endmodule // fgt_regs

// [bench/tb_fgt_regs.sv]
// Self-checking testbench for the fine gain trim register bank
`timescale 1ns/1ns
module tb_fgt_regs;
  logic                     aclk;
  logic                     aresetn;
  logic [11:0]              awaddr;
  logic                     awvalid;
  logic                     awready;
  logic [31:0]              wdata;
  logic [3:0]               wstrb;
  logic                     wvalid;
  logic                     wready;
  logic [1:0]               bresp;
  logic                     bvalid;
  logic                     bready;
  logic [11:0]              araddr;
  logic                     arvalid;
  logic                     arready;
  logic [31:0]              rdata;
  logic [1:0]               rresp;
  logic                     rvalid;
  logic                     rready;
  logic                     fuse_load_valid;
  fgt_pkg::fgt_bank_t       fuse_trim_bank;
  fgt_pkg::fgt_input_sel_t  core_input_sel;
  fgt_pkg::fgt_core_trims_t core_trims;
  logic                     fuse_loaded;
  fgt_pkg::fgt_bank_t       exp_bank;
  integer                   seed;
  int                       n_fail;
  int                       n_tests;
  logic [1:0]               resp;
  logic [31:0]              data;
  logic [7:0]               v;

  fgt_regs dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fuse_load_valid(fuse_load_valid), .fuse_trim_bank(fuse_trim_bank),
    .core_input_sel(core_input_sel), .core_trims(core_trims), .fuse_loaded(fuse_loaded)
  );

  // Clock, 10 ns period
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Watchdog against a hung handshake
  initial
  begin
    #200000;
    n_fail++;
    summarize();
  end

  // Byte address of a bank slot
  function automatic logic [11:0] addr_of(input int i);
    return {fgt_pkg::IDX_CORE0 + 10'(i), 2'b00};
  endfunction

  // Trims each core should apply
  function automatic fgt_pkg::fgt_core_trims_t exp_core(input fgt_pkg::fgt_bank_t b,
                                                        input fgt_pkg::fgt_input_sel_t s);
    fgt_pkg::fgt_core_trims_t t;
    t.c0 = b[0][4:0];
    t.c1 = b[1][4:0];
    t.c2 = s.sel_b ? b[3][4:0] : b[2][4:0];
    t.c3 = s.sel_d ? b[5][4:0] : b[4][4:0];
    t.c4 = b[6][4:0];
    t.c5 = b[7][4:0];
    return t;
  endfunction

  task automatic chk_val(input string name, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk_resp(input string name, input logic [1:0] e, input logic [1:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask

  // Write cycle; address and data offered together
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    r = 2'h3;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do
      @(posedge aclk);
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  // Read cycle
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    d = 32'hxxxx_xxxx;
    r = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    do
      @(posedge aclk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr <= ~a;
    rready <= 1'b1;
    do
      @(posedge aclk);
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Read back every slot and compare core trims
  task automatic check_bank(input string name);
    for (int i = 0; i < 8; i++)
    begin
      axi_read(addr_of(i), data, resp);
      chk_resp("read resp", fgt_pkg::RESP_OKAY, resp);
      chk_val("trim reg", {24'h0, exp_bank[i]}, data);
    end
    repeat (2) @(posedge aclk);
    chk_val("core_trims", {2'h0, exp_core(exp_bank, core_input_sel)}, {2'h0, core_trims});
    $display("test %s done", name);
  endtask

  // State just after reset, plus an unmapped read
  task automatic check_reset(input string name);
    exp_bank = '0;
    chk_val("fuse_loaded", 32'h0, {31'h0, fuse_loaded});
    axi_read(12'h000, data, resp);
    chk_resp("unmapped read resp", fgt_pkg::RESP_SLVERR, resp);
    chk_val("unmapped read data", 32'h0, data);
    check_bank(name);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    seed = 41;
    n_fail = 0;
    n_tests = 0;
    aresetn <= 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= '0;
    {araddr, arvalid, rready, fuse_load_valid, fuse_trim_bank} <= '0;
    core_input_sel <= '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_reset("reset values");
    // Back-to-back random writes, each round then checked under one of the four input selections in turn
    for (int r = 0; r < 4; r++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        v = 8'($random(seed)) & 8'h1f;
        axi_write(addr_of(i), {24'($random(seed)), v}, 4'hf, resp);
        chk_resp("write resp", fgt_pkg::RESP_OKAY, resp);
        exp_bank[i] = v;
      end
      core_input_sel <= 2'(r);
      check_bank("random writes");
    end
    // Refused and ignored writes leave the bank alone
    axi_write(12'hda4, 32'h0000_0015, 4'hf, resp);
    chk_resp("unmapped write resp", fgt_pkg::RESP_SLVERR, resp);
    axi_write(addr_of(2), 32'h0000_001f, 4'he, resp);
    chk_resp("no strobe write resp", fgt_pkg::RESP_OKAY, resp);
    axi_write(12'hda0, 32'h0000_0007, 4'hf, resp);
    chk_resp("status write resp", fgt_pkg::RESP_OKAY, resp);
    check_bank("refused writes");
    axi_read(12'hda0, data, resp);
    chk_val("status", {29'h0, core_input_sel.sel_d, core_input_sel.sel_b, 1'b0}, data);
    // Fuse load replaces every register
    fuse_trim_bank <= {$random(seed), $random(seed)};
    fuse_load_valid <= 1'b1;
    @(posedge aclk);
    exp_bank = fuse_trim_bank;
    fuse_load_valid <= 1'b0;
    @(posedge aclk);
    chk_val("fuse_loaded", 32'h1, {31'h0, fuse_loaded});
    check_bank("fuse load");
    // Software write after the load overrides one slot
    axi_write(addr_of(5), 32'h0000_000b, 4'hf, resp);
    exp_bank[5] = 8'h0b;
    core_input_sel <= 2'h2;
    check_bank("write after fuse");
    // Second reset in mid-run
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_reset("second reset");
    summarize();
  end
endmodule // tb_fgt_regs
